// >>> verilog/mac_filter_consts.vh
// constants for the layer-2 frame filter bank
`ifndef MAC_FILTER_CONSTS_VH
`define MAC_FILTER_CONSTS_VH

// filter bank size and index width
`define FLT_COUNT 8
`define FLT_IDX_W 3

// field match modes
`define MODE_W 2
`define MODE_IGNORE 2'h0
`define MODE_EQUAL 2'h1

// control word field positions
`define CTRL_W 6
`define CTRL_SRC 1:0
`define CTRL_DST 3:2
`define CTRL_ETY 5:4

// wishbone address layout, word addressed
`define ADR_W 12
`define WADR_W 10
`define WADR_AREA 9:7
`define WADR_FLT 6:4
`define WADR_WORD 3:0
`define AREA_FILTERS 3'h0
`define AREA_GLOBAL 3'h1

// word numbers inside one filter, byte stride 0x40
`define WD_CTRL 4'h0
`define WD_SRC_LO 4'h1
`define WD_SRC_HI 4'h2
`define WD_SRC_MSK_LO 4'h3
`define WD_SRC_MSK_HI 4'h4
`define WD_DST_LO 4'h5
`define WD_DST_HI 4'h6
`define WD_DST_MSK_LO 4'h7
`define WD_DST_MSK_HI 4'h8
`define WD_ETY 4'h9

// global words, byte 0x200, 0x204, 0x208
`define GWD_RESULT 4'h0
`define GWD_SEEN 4'h1
`define GWD_HITS 4'h2

// reset values
`define RST_CTRL 6'h00
`define RST_ADDR 48'h0000_0000_0000
`define RST_ETY 16'h0000
`define RST_WORD 32'h0000_0000
`endif

// >>> verilog/mac_frame_filter.v
// layer-2 frame filter bank with wishbone configuration port
`include "mac_filter_consts.vh"

module mac_frame_filter #(
    parameter NUM_FILTERS = `FLT_COUNT
) (
    input wire clk,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire rx_hdr_valid,
    input wire [47:0] rx_dst_addr,
    input wire [47:0] rx_src_addr,
    input wire [15:0] rx_ethertype,
    output wire sel_valid,
    output wire sel_hit,
    output wire [`FLT_IDX_W-1:0] sel_index
);

    // per filter configuration
    reg [`CTRL_W-1:0] ctrl_q [0:`FLT_COUNT-1];
    reg [47:0] src_val_q [0:`FLT_COUNT-1];
    reg [47:0] src_msk_q [0:`FLT_COUNT-1];
    reg [47:0] dst_val_q [0:`FLT_COUNT-1];
    reg [47:0] dst_msk_q [0:`FLT_COUNT-1];
    reg [15:0] ety_val_q [0:`FLT_COUNT-1];
    reg [15:0] ety_msk_q [0:`FLT_COUNT-1];

    // bus state
    reg ack_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // result and statistics state
    reg res_valid_q;
    reg res_hit_q;
    reg [`FLT_IDX_W-1:0] res_index_q;
    reg last_hit_q;
    reg [`FLT_IDX_W-1:0] last_index_q;
    reg [31:0] seen_cnt_q;
    reg [31:0] hit_cnt_q;

    // match network
    reg [`FLT_COUNT-1:0] flt_hit;
    reg any_hit;
    reg [`FLT_IDX_W-1:0] win_index;
    integer i;
    integer j;

    // address decode
    wire [`WADR_W-1:0] wadr;
    wire [2:0] area;
    wire [`FLT_IDX_W-1:0] fidx;
    wire [3:0] word;
    wire flt_ok;
    wire req;
    wire wr_en;
    wire gl_wr;
    wire cfg_wr;
    wire clr_seen;
    wire clr_hits;
    wire [31:0] wr_word;

    assign wadr = wb_adr_i[`ADR_W-1:2];
    assign area = wadr[`WADR_AREA];
    assign fidx = wadr[`WADR_FLT];
    assign word = wadr[`WADR_WORD];
    assign flt_ok = (area == `AREA_FILTERS) && ({29'h0, fidx} < NUM_FILTERS);
    assign req = wb_cyc_i && wb_stb_i;
    // a write lands on the edge where the master sees ack high
    assign wr_en = req && wb_we_i && ack_q;
    assign gl_wr = wr_en && (area == `AREA_GLOBAL);
    // configuration write, landing with ack
    assign cfg_wr = wr_en && flt_ok;
    // any write to a counter word clears it
    assign clr_seen = gl_wr && (word == `GWD_SEEN);
    assign clr_hits = gl_wr && (word == `GWD_HITS);

    // byte lane merge of a write into an old word
    function [31:0] merge_bytes;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            merge_bytes = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge_bytes[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
        end
    endfunction

    // masked comparison, both sides masked identically
    function field_match;
        input [47:0] rx_v;
        input [47:0] cfg_v;
        input [47:0] msk_v;
        begin
            field_match = (((rx_v & msk_v) ^ (cfg_v & msk_v)) == `RST_ADDR);
        end
    endfunction

    // only the equality code enables a field, spare codes act as ignore
    function mode_on;
        input [`MODE_W-1:0] mode;
        begin
            case (mode)
                `MODE_EQUAL: mode_on = 1'b1;
                default: mode_on = 1'b0;
            endcase
        end
    endfunction

    // per filter decision and priority pick, filter 0 highest
    always @* begin
        flt_hit = {`FLT_COUNT{1'b0}};
        any_hit = 1'b0;
        win_index = {`FLT_IDX_W{1'b0}};
        for (i = 0; i < NUM_FILTERS; i = i + 1) begin
            // a field left in ignore mode vetoes the whole filter
            flt_hit[i] = mode_on(ctrl_q[i][`CTRL_SRC])
                && field_match(rx_src_addr, src_val_q[i], src_msk_q[i])
                && mode_on(ctrl_q[i][`CTRL_DST])
                && field_match(rx_dst_addr, dst_val_q[i], dst_msk_q[i])
                && mode_on(ctrl_q[i][`CTRL_ETY])
                && field_match({32'h0, rx_ethertype}, {32'h0, ety_val_q[i]},
                               {32'h0, ety_msk_q[i]});
        end
        // scan from lowest priority up so the highest wins
        for (i = NUM_FILTERS - 1; i >= 0; i = i - 1) begin
            if (flt_hit[i]) begin
                any_hit = 1'b1;
                win_index = i[`FLT_IDX_W-1:0];
            end
        end
    end

    // registered verdict, one cycle after the header strobe
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            res_valid_q <= 1'b0;
            res_hit_q <= 1'b0;
            res_index_q <= {`FLT_IDX_W{1'b0}};
            last_hit_q <= 1'b0;
            last_index_q <= {`FLT_IDX_W{1'b0}};
        end else begin
            res_valid_q <= rx_hdr_valid;
            if (rx_hdr_valid) begin
                res_hit_q <= any_hit;
                res_index_q <= win_index;
                last_hit_q <= any_hit;
                last_index_q <= win_index;
            end else begin
                res_hit_q <= 1'b0;
                res_index_q <= {`FLT_IDX_W{1'b0}};
            end
        end
    end

    // frame counters, cleared by a write, a count in the clearing cycle reloads 1
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_cnt_q <= `RST_WORD;
            hit_cnt_q <= `RST_WORD;
        end else begin
            if (rx_hdr_valid) begin
                seen_cnt_q <= clr_seen ? 32'h0000_0001
                                                             : seen_cnt_q + 32'h0000_0001;
            end else if (clr_seen) begin
                seen_cnt_q <= `RST_WORD;
            end
            if (rx_hdr_valid && any_hit) begin
                hit_cnt_q <= clr_hits ? 32'h0000_0001
                                                            : hit_cnt_q + 32'h0000_0001;
            end else if (clr_hits) begin
                hit_cnt_q <= `RST_WORD;
            end
        end
    end

    // old word with the written byte lanes merged in
    assign wr_word = merge_bytes(rdata_d, wb_dat_i, wb_sel_i);

    // configuration writes with byte lanes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (j = 0; j < `FLT_COUNT; j = j + 1) begin
                ctrl_q[j] <= `RST_CTRL;
                src_val_q[j] <= `RST_ADDR;
                src_msk_q[j] <= `RST_ADDR;
                dst_val_q[j] <= `RST_ADDR;
                dst_msk_q[j] <= `RST_ADDR;
                ety_val_q[j] <= `RST_ETY;
                ety_msk_q[j] <= `RST_ETY;
            end
        end else if (cfg_wr) begin
            case (word)
                `WD_CTRL: begin
                    ctrl_q[fidx] <= wr_word[`CTRL_W-1:0];
                end
                `WD_SRC_LO: begin
                    src_val_q[fidx][31:0] <= wr_word;
                end
                `WD_SRC_HI: begin
                    src_val_q[fidx][47:32] <= wr_word[15:0];
                end
                `WD_SRC_MSK_LO: begin
                    src_msk_q[fidx][31:0] <= wr_word;
                end
                `WD_SRC_MSK_HI: begin
                    src_msk_q[fidx][47:32] <= wr_word[15:0];
                end
                `WD_DST_LO: begin
                    dst_val_q[fidx][31:0] <= wr_word;
                end
                `WD_DST_HI: begin
                    dst_val_q[fidx][47:32] <= wr_word[15:0];
                end
                `WD_DST_MSK_LO: begin
                    dst_msk_q[fidx][31:0] <= wr_word;
                end
                `WD_DST_MSK_HI: begin
                    dst_msk_q[fidx][47:32] <= wr_word[15:0];
                end
                `WD_ETY: begin
                    ety_val_q[fidx] <= wr_word[15:0];
                    ety_msk_q[fidx] <= wr_word[31:16];
                end
                default: begin
                end
            endcase
        end
    end

    // read mux, unmapped words read zero
    always @* begin
        rdata_d = `RST_WORD;
        if (flt_ok) begin
            case (word)
                `WD_CTRL: rdata_d = {26'h0, ctrl_q[fidx]};
                `WD_SRC_LO: rdata_d = src_val_q[fidx][31:0];
                `WD_SRC_HI: rdata_d = {16'h0, src_val_q[fidx][47:32]};
                `WD_SRC_MSK_LO: rdata_d = src_msk_q[fidx][31:0];
                `WD_SRC_MSK_HI: rdata_d = {16'h0, src_msk_q[fidx][47:32]};
                `WD_DST_LO: rdata_d = dst_val_q[fidx][31:0];
                `WD_DST_HI: rdata_d = {16'h0, dst_val_q[fidx][47:32]};
                `WD_DST_MSK_LO: rdata_d = dst_msk_q[fidx][31:0];
                `WD_DST_MSK_HI: rdata_d = {16'h0, dst_msk_q[fidx][47:32]};
                `WD_ETY: rdata_d = {ety_msk_q[fidx], ety_val_q[fidx]};
                default: rdata_d = `RST_WORD;
            endcase
        end else if (area == `AREA_GLOBAL) begin
            case (word)
                `GWD_RESULT: rdata_d = {23'h0, last_hit_q, 5'h0, last_index_q};
                `GWD_SEEN: rdata_d = seen_cnt_q;
                `GWD_HITS: rdata_d = hit_cnt_q;
                default: rdata_d = `RST_WORD;
            endcase
        end
    end

    // ack one cycle after the request, dropped the cycle after
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rdata_q <= `RST_WORD;
        end else begin
            ack_q <= req && !ack_q;
            if (req && !ack_q) begin
                rdata_q <= wb_we_i ? `RST_WORD : rdata_d;
            end
        end
    end

    // outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign sel_valid = res_valid_q;
    assign sel_hit = res_hit_q;
    assign sel_index = res_index_q;

endmodule

// >>> verif/mac_frame_filter_asserts.sv
// port checker for the frame filter bank
module mac_frame_filter_asserts #(
    parameter NUM_FILTERS = 8
) (
    input wire clk,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire rx_hdr_valid,
    input wire sel_valid,
    input wire sel_hit,
    input wire [2:0] sel_index
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // bus request answered by a single-cycle ack
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_on_time: assert property (s_req |=> s_ack_pulse) else $error("ack late or long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_rdata_holds: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved without request");
    // one verdict per header strobe, one cycle later
    a_verdict_next: assert property (rx_hdr_valid |=> sel_valid)
        else $error("verdict missing");
    a_verdict_cause: assert property (sel_valid |-> $past(rx_hdr_valid))
        else $error("verdict without header");
    a_hit_in_verdict: assert property (sel_hit |-> sel_valid)
        else $error("hit outside verdict");
    a_miss_index_zero: assert property (!sel_hit |-> sel_index == 3'h0)
        else $error("index set without hit");
    a_index_in_bank: assert property (sel_hit |-> sel_index < NUM_FILTERS)
        else $error("index beyond bank");
endmodule

bind mac_frame_filter mac_frame_filter_asserts #(.NUM_FILTERS(NUM_FILTERS)) u_chk (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .rx_hdr_valid(rx_hdr_valid), .sel_valid(sel_valid),
    .sel_hit(sel_hit), .sel_index(sel_index));

// >>> verif/mac_rx_model.sv
// header source standing in for the mac receive path
module mac_rx_model (
    input wire clk,
    output logic rx_hdr_valid,
    output logic [47:0] rx_dst_addr,
    output logic [47:0] rx_src_addr,
    output logic [15:0] rx_ethertype
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle at time zero
    initial begin
        rx_hdr_valid = 1'b0;
        rx_dst_addr = 48'h0;
        rx_src_addr = 48'h0;
        rx_ethertype = 16'h0;
    end
    // one strobe; fields scrambled once no longer valid
    task automatic send(input logic [47:0] d, input logic [47:0] s, input logic [15:0] e);
        @(posedge clk);
        rx_hdr_valid <= 1'b1;
        rx_dst_addr <= d;
        rx_src_addr <= s;
        rx_ethertype <= e;
        @(posedge clk);
        rx_hdr_valid <= 1'b0;
        rx_dst_addr <= ~d;
        rx_src_addr <= ~s;
        rx_ethertype <= ~e;
    endtask
endmodule

// >>> verif/test_mac_frame_filter.sv
// self-checking bench for the frame filter bank
`include "mac_filter_consts.vh"
module test_mac_frame_filter;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [47:0] A = 48'h0a1b_2c3d_4e5f;
    localparam logic [47:0] B = 48'h1122_3344_5566;
    localparam logic [47:0] F = 48'hffff_ffff_ffff;
    localparam logic [15:0] T = 16'h88b5;
    logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_hdr_valid, sel_valid, sel_hit;
    logic [`ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [47:0] rx_dst_addr, rx_src_addr;
    logic [15:0] rx_ethertype;
    logic [2:0] sel_index;
    int bad_count = 0;
    int n_compared = 0;
    logic [3:0] sel_next = 4'hf;
    mac_frame_filter #(.NUM_FILTERS(8)) dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_hdr_valid(rx_hdr_valid), .rx_dst_addr(rx_dst_addr), .rx_src_addr(rx_src_addr),
        .rx_ethertype(rx_ethertype), .sel_valid(sel_valid), .sel_hit(sel_hit),
        .sel_index(sel_index));
    mac_rx_model rx (.clk(clk), .rx_hdr_valid(rx_hdr_valid), .rx_dst_addr(rx_dst_addr),
        .rx_src_addr(rx_src_addr), .rx_ethertype(rx_ethertype));
    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic single wishbone cycle, bounded wait for ack
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel_next;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            test_done();
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    // whole filter setup, ten words
    task automatic cfg(input int f, input logic [5:0] c, input logic [47:0] s, sm, d, dm,
                       input logic [15:0] e, em);
        logic [31:0] w [10];
        w = '{{26'h0, c}, s[31:0], {16'h0, s[47:32]}, sm[31:0], {16'h0, sm[47:32]},
              d[31:0], {16'h0, d[47:32]}, dm[31:0], {16'h0, dm[47:32]}, {em, e}};
        for (int k = 0; k < 10; k++) begin
            wb(1'b1, 12'(f * 64 + k * 4), w[k]);
        end
    endtask
    // send one header and judge the verdict a cycle later
    task automatic frame(input logic [47:0] d, s, input logic [15:0] e, input logic h,
                         input logic [2:0] i);
        rx.send(d, s, e);
        #1;
        check(sel_valid, 1'b1);
        check(sel_hit, h);
        check(sel_index, i);
    endtask
    task automatic t_reset_state();
        wb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, 12'h1fc, 32'h0);
        check(rd, 32'h0);
        frame(B, A, T, 1'b0, 3'h0);
        $display("reset state done");
    endtask
    task automatic t_masks();
        cfg(3, 6'h15, A, 48'hffff_ffff_ff00, B, F, T, 16'hff00);
        frame(B, A, T, 1'b1, 3'h3);
        frame(B, A ^ 48'h0000_0000_00ff, T, 1'b1, 3'h3);
        frame(B, A ^ 48'h0000_0000_0100, T, 1'b0, 3'h0);
        frame(B ^ 48'h8000_0000_0000, A, T, 1'b0, 3'h0);
        frame(B, A, T ^ 16'h00ff, 1'b1, 3'h3);
        frame(B, A, T ^ 16'h0100, 1'b0, 3'h0);
        $display("mask test done");
    endtask
    task automatic t_modes();
        logic [5:0] c;
        for (int i = 0; i < 3; i++) begin
            for (int m = 0; m < 3; m += 2) begin
                c = (6'h15 & ~(6'h3 << 2 * i)) | 6'(m << 2 * i);
                wb(1'b1, 12'h0c0, {26'h0, c});
                frame(B, A, T, 1'b0, 3'h0);
            end
        end
        wb(1'b1, 12'h0c0, 32'h15);
        wb(1'b0, 12'h0c0, 32'h0);
        check(rd, 32'h15);
        frame(B, A, T, 1'b1, 3'h3);
        $display("mode test done");
    endtask
    task automatic t_priority();
        cfg(1, 6'h15, A, F, B, F, T, 16'hffff);
        frame(B, A, T, 1'b1, 3'h1);
        cfg(7, 6'h15, B, F, A, F, T, 16'hffff);
        frame(A, B, T, 1'b1, 3'h7);
        $display("priority test done");
    endtask
    // frame counters, last result word, single byte lane write
    task automatic t_stats();
        wb(1'b1, 12'h204, 32'h0);
        wb(1'b1, 12'h208, 32'hffff_ffff);
        frame(A, A, T, 1'b0, 3'h0);
        frame(B, A, T, 1'b1, 3'h1);
        frame(A, B, T, 1'b1, 3'h7);
        wb(1'b0, 12'h204, 32'h0);
        check(rd, 32'h3);
        wb(1'b0, 12'h208, 32'h0);
        check(rd, 32'h2);
        wb(1'b0, 12'h200, 32'h0);
        check(rd, 32'h107);
        sel_next = 4'h2;
        wb(1'b1, 12'h0c4, 32'h0000_aa00);
        sel_next = 4'hf;
        wb(1'b0, 12'h0c4, 32'h0);
        check(rd, 32'h2c3d_aa5f);
        $display("stats test done");
    endtask
    initial begin
        rstn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        rd = 32'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset_state();
        t_masks();
        t_modes();
        t_priority();
        t_stats();
        test_done();
    end
endmodule
